//--- ewc_pkg.sv
// package for the external wake/interrupt combiner: register map,
// field layout, reset values and the per-input configuration carrier.
// assumes a 32-bit axi4-lite slave port with byte addresses.
package ewc_pkg;

  localparam int NUM_INPUTS = 4;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CFG_ONE = 10'h380;
  localparam logic [9:0] IDX_CFG_TWO = 10'h381;
  localparam logic [9:0] IDX_CFG_THREE = 10'h382;
  localparam logic [9:0] IDX_CFG_FOUR = 10'h383;
  localparam logic [9:0] IDX_FLAGS = 10'h384;
  localparam logic [9:0] IDX_EVT_STATUS = 10'h385;
  localparam logic [9:0] IDX_EVT_MASK = 10'h386;

  // field positions in a trigger configuration register
  localparam int ENABLE_BIT = 0;
  localparam int COND_LSB = 4;
  localparam int COND_MSB = 5;

  // active-condition codes
  typedef enum logic [1:0] {
    EWC_LOW_LEVEL = 2'h0,
    EWC_HIGH_LEVEL = 2'h1,
    EWC_FALL_EDGE = 2'h2,
    EWC_RISE_EDGE = 2'h3
  } ewc_cond_t;

  // per-input configuration carrier
  typedef struct packed {
    ewc_cond_t cond;
    logic en;
  } ewc_cfg_t;

  localparam ewc_cfg_t CFG_RESET = '{cond: EWC_FALL_EDGE, en: 1'b0};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- ewc_top.sv
// top of the external wake/interrupt combiner: four pin inputs, per-input
// condition detection, read-to-clear flags, combined request outputs and
// an axi4-lite register slave with a maskable event interrupt.
// assumes the pins are asynchronous to SYS_CLK and the bus is on SYS_CLK.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module ewc_top (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [3:0] EXT_REQ_PIN,
  output logic WAKE_REQ,
  output logic IRQ_SRC,
  output logic EVT_IRQ,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  localparam int N = ewc_pkg::NUM_INPUTS;

  // register select from a byte address; 0 = cfg one .. 6 = mask, 7 = none
  function automatic logic [2:0] reg_sel(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    if (addr[1:0] != 2'h0) reg_sel = 3'h7;
    else if (idx == ewc_pkg::IDX_CFG_ONE) reg_sel = 3'h0;
    else if (idx == ewc_pkg::IDX_CFG_TWO) reg_sel = 3'h1;
    else if (idx == ewc_pkg::IDX_CFG_THREE) reg_sel = 3'h2;
    else if (idx == ewc_pkg::IDX_CFG_FOUR) reg_sel = 3'h3;
    else if (idx == ewc_pkg::IDX_FLAGS) reg_sel = 3'h4;
    else if (idx == ewc_pkg::IDX_EVT_STATUS) reg_sel = 3'h5;
    else if (idx == ewc_pkg::IDX_EVT_MASK) reg_sel = 3'h6;
    else reg_sel = 3'h7;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers and condition detection

  logic [N-1:0] sync_a;
  logic [N-1:0] sync_b;
  logic [N-1:0] sync_prev;
  logic [N-1:0] match;
  ewc_pkg::ewc_cfg_t cfg [N];

  // two flops per pin, then one more sample for edge comparison
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // the chain starts at the idle-high level of the pins, so release
      // of reset does not look like a rising edge on every input
      sync_a <= {N{1'b1}};
      sync_b <= {N{1'b1}};
      sync_prev <= {N{1'b1}};
    end else begin
      sync_a <= EXT_REQ_PIN;
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  // condition match per input; edges come from consecutive samples
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_det
      always_comb begin
        case (cfg[gi].cond)
          ewc_pkg::EWC_LOW_LEVEL: match[gi] = !sync_b[gi];
          ewc_pkg::EWC_HIGH_LEVEL: match[gi] = sync_b[gi];
          ewc_pkg::EWC_FALL_EDGE: match[gi] = sync_prev[gi] && !sync_b[gi];
          ewc_pkg::EWC_RISE_EDGE: match[gi] = !sync_prev[gi] && sync_b[gi];
          default: match[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes

  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic rd_valid;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic b_valid;
  logic [1:0] b_resp;

  // write address and data are taken in either order, then answered
  wire aw_take = S_AXI_AWVALID && !aw_held && !b_valid;
  wire w_take = S_AXI_WVALID && !w_held && !b_valid;
  wire wr_do = aw_held && w_held && !b_valid;
  wire [2:0] wr_sel = reg_sel(aw_addr);
  wire wr_lane = w_strb[0];
  wire rd_take = S_AXI_ARVALID && !rd_valid;
  wire [2:0] rd_sel = reg_sel(S_AXI_ARADDR);
  wire flags_read = rd_take && (rd_sel == 3'h4);

  assign S_AXI_AWREADY = !aw_held && !b_valid;
  assign S_AXI_WREADY = !w_held && !b_valid;
  assign S_AXI_ARREADY = !rd_valid;
  assign S_AXI_BVALID = b_valid;
  assign S_AXI_BRESP = b_resp;
  assign S_AXI_RVALID = rd_valid;
  assign S_AXI_RDATA = rd_data;
  assign S_AXI_RRESP = rd_resp;

  // hold the halves of a write until both are in
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      b_valid <= 1'b0;
      b_resp <= ewc_pkg::RESP_OKAY;
    end else begin
      if (aw_take) aw_held <= 1'b1;
      else if (wr_do) aw_held <= 1'b0;
      if (aw_take) aw_addr <= S_AXI_AWADDR;
      if (w_take) w_held <= 1'b1;
      else if (wr_do) w_held <= 1'b0;
      if (w_take) w_data <= S_AXI_WDATA;
      if (w_take) w_strb <= S_AXI_WSTRB;
      if (wr_do) b_valid <= 1'b1;
      else if (S_AXI_BREADY) b_valid <= 1'b0;
      if (wr_do) begin
        b_resp <= (wr_sel == 3'h7) ? ewc_pkg::RESP_SLVERR
                                   : ewc_pkg::RESP_OKAY;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration, flags and event interrupt registers

  logic [N-1:0] flags;
  logic [N-1:0] evt_status;
  logic [N-1:0] evt_mask;
  logic [N-1:0] next_flags;
  logic [N-1:0] flag_set;
  logic [N-1:0] evt_w1c;

  // set wins over the clearing read so no event is lost in that cycle
  generate
    for (gi = 0; gi < N; gi++) begin : g_flag
      assign flag_set[gi] = cfg[gi].en && match[gi];
      assign next_flags[gi] = flag_set[gi] || (flags[gi] && !flags_read);
      assign evt_w1c[gi] = wr_do && wr_lane && (wr_sel == 3'h5)
                           && w_data[gi];

      // each input owns its own register; writes to others leave it alone
      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          cfg[gi] <= ewc_pkg::CFG_RESET;
        end else if (wr_do && wr_lane && wr_sel == 3'(gi)) begin
          cfg[gi].cond <=
            ewc_pkg::ewc_cond_t'(w_data[ewc_pkg::COND_MSB:ewc_pkg::COND_LSB]);
          cfg[gi].en <= w_data[ewc_pkg::ENABLE_BIT];
        end
      end
    end
  endgenerate

  // flags clear on read; status is sticky, write one to clear
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags <= 4'h0;
      evt_status <= 4'h0;
      evt_mask <= 4'h0;
    end else begin
      flags <= next_flags;
      evt_status <= flag_set | (evt_status & ~evt_w1c);
      if (wr_do && wr_lane && wr_sel == 3'h6) evt_mask <= w_data[3:0];
    end
  end

  // combined source to clock generator and interrupt controller
  assign WAKE_REQ = |flags;
  assign IRQ_SRC = |flags;
  assign EVT_IRQ = |(evt_status & evt_mask);

  //////////////////////////////////////////////////////////////////////////
  // read data; the value is captured as the address is taken

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (rd_sel)
      3'h0, 3'h1, 3'h2, 3'h3: begin
        rd_mux[ewc_pkg::COND_MSB:ewc_pkg::COND_LSB] = cfg[rd_sel[1:0]].cond;
        rd_mux[ewc_pkg::ENABLE_BIT] = cfg[rd_sel[1:0]].en;
      end
      3'h4: rd_mux[3:0] = flags;
      3'h5: rd_mux[3:0] = evt_status;
      3'h6: rd_mux[3:0] = evt_mask;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_valid <= 1'b0;
      rd_data <= 32'h0000_0000;
      rd_resp <= ewc_pkg::RESP_OKAY;
    end else begin
      if (rd_take) rd_valid <= 1'b1;
      else if (S_AXI_RREADY) rd_valid <= 1'b0;
      if (rd_take) rd_data <= rd_mux;
      if (rd_take) begin
        rd_resp <= (rd_sel == 3'h7) ? ewc_pkg::RESP_SLVERR
                                    : ewc_pkg::RESP_OKAY;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  // both consumers see one and the same or of the flags
  chk_combined_or: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (WAKE_REQ == IRQ_SRC) && (IRQ_SRC == (flags != 4'h0)))
    else $error("combined request differs from flag or");

  // a match on an enabled input in one cycle is on both outputs in the next
  chk_request_follows: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (flag_set != 4'h0) |=> WAKE_REQ && IRQ_SRC)
    else $error("combined request missing after a match");

  chk_read_withdraws: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    flags_read && (flag_set == 4'h0) |=> !IRQ_SRC)
    else $error("combined request held after flag read");

  chk_flags_upper_zero: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    flags_read |=> rd_valid && (rd_data[31:4] == 28'h0)
                   && (rd_data[3:0] == $past(flags)))
    else $error("flag read data wrong");

  chk_cond_written: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    wr_do && wr_lane && (wr_sel == 3'h2)
    |=> cfg[2].cond == $past(w_data[5:4])
        && cfg[1] == $past(cfg[1]))
    else $error("condition field not written alone");

  generate
    for (gi = 0; gi < N; gi++) begin : g_chk
      chk_flag_needs_en: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        $rose(flags[gi]) |-> $past(cfg[gi].en))
        else $error("flag set while input disabled");

      chk_level_again: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        cfg[gi].en && cfg[gi].cond == ewc_pkg::EWC_HIGH_LEVEL
        && sync_b[gi] && flags_read |=> flags[gi])
        else $error("held level did not set flag again");

      chk_rise_sampled: assert property (
        @(posedge SYS_CLK) disable iff (!RST_N)
        cfg[gi].cond == ewc_pkg::EWC_RISE_EDGE && $rose(flags[gi])
        |-> $past(sync_b[gi]) && !$past(sync_prev[gi]))
        else $error("rising flag without sampled rise");
    end
  endgenerate

  chk_reset_cfg: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    $rose(RST_N) |-> cfg[0] == ewc_pkg::CFG_RESET && flags == 4'h0)
    else $error("configuration not at reset value");

  // a mask write in the same cycle may legally drop the interrupt
  chk_evt_irq: assert property (
    @(posedge SYS_CLK) disable iff (!RST_N)
    (flag_set & evt_mask) != 4'h0 && !(wr_do && wr_lane && wr_sel == 3'h6)
    |=> EVT_IRQ)
    else $error("event interrupt missing");

endmodule

//--- ewc_pin_src.sv
// pin source model: the four external request pins of the combiner.
// assumes the bench calls drive just after a rising or a falling edge of the clock.
`timescale 1ns/100ps
module ewc_pin_src (
  output logic [3:0] pins
);
  // pins idle high; each value is a level held until the next call,
  // so the synchroniser always gets several edges to see it
  initial begin
    pins = 4'hF;
  end
  task automatic drive(input logic [3:0] v);
    pins <= v;
  endtask
endmodule

//--- tb_external_wake_interrupt_combiner.sv
// self-checking bench for ewc_top: axi4-lite master, pin source model
// and a reference model of flags, event status and request outputs.
// assumes register byte address is four times the package index.
`timescale 1ns/100ps
module tb_external_wake_interrupt_combiner;
  logic clk, rst_n, wake, irq, evt_irq;
  logic [3:0] pins, en, mp, ef, ev, mk;
  logic [3:0] wstrb;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [1:0] cd [4];
  int errors, checks_done, cyc;

  ewc_pin_src src (.pins(pins));
  ewc_top dut (.SYS_CLK(clk), .RST_N(rst_n), .EXT_REQ_PIN(pins),
    .WAKE_REQ(wake), .IRQ_SRC(irq), .EVT_IRQ(evt_irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard: whole run is well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // ready is sampled mid-cycle: it is set by registered state, so it
  // holds through the next rising edge, where the transfer happens
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ap, dp, ta, tw, ok;
    @(posedge clk);
    ap = 1'b1;
    dp = 1'b1;
    ok = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!ok) begin
      @(negedge clk);
      ta = ap & awready;
      tw = dp & wready;
      ok = bvalid;
      r = bresp;
      @(posedge clk);
      ap = ap & ~ta;
      dp = dp & ~tw;
      awvalid <= ap;
      wvalid <= dp;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    logic ap, ta, ok;
    @(posedge clk);
    ap = 1'b1;
    ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok) begin
      @(negedge clk);
      ta = ap & arready;
      ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      ap = ap & ~ta;
      arvalid <= ap;
    end
    rready <= 1'b0;
  endtask
  function automatic logic [11:0] ad(input logic [9:0] i);
    return {i, 2'h0};
  endfunction
  // byte address of the configuration register of input i
  function automatic logic [11:0] ca(input int i);
    return ad(ewc_pkg::IDX_CFG_ONE + 10'(i));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reference model: level matches of enabled inputs
  function automatic logic [3:0] lvl(input logic [3:0] p);
    for (int i = 0; i < 4; i++)
      lvl[i] = en[i] && ((cd[i] == 2'h0 && !p[i]) || (cd[i] == 2'h1 && p[i]));
  endfunction
  // new pin value: edges compare the old and new level per input
  task automatic step(input logic [3:0] nv);
    logic [3:0] h;
    h = lvl(nv);
    for (int i = 0; i < 4; i++)
      if (en[i] && cd[i][1])
        h[i] = (mp[i] != nv[i]) && (nv[i] == cd[i][0]);
    ef = ef | h;
    ev = ev | h;
    mp = nv;
    src.drive(nv);
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {errors, checks_done, cyc} = 0;
    {en, ef, ev} = 12'h0;
    mp = 4'hF;
    void'($urandom(58));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      cd[i] = 2'h2;
      rd(ca(i));
      chk(d, 32'h20);
    end
    rd(ad(ewc_pkg::IDX_FLAGS));
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, ewc_pkg::RESP_OKAY});
    wr(ad(ewc_pkg::IDX_EVT_MASK) + 12'h4, 32'hF);
    chk({30'h0, r}, {30'h0, ewc_pkg::RESP_SLVERR});
    // unmapped and unaligned reads answer an error with zero data
    rd(ad(ewc_pkg::IDX_EVT_MASK) + 12'h4);
    chk({30'h0, r}, {30'h0, ewc_pkg::RESP_SLVERR});
    chk(d, 32'h0);
    rd(ad(ewc_pkg::IDX_CFG_ONE) + 12'h1);
    chk({30'h0, r}, {30'h0, ewc_pkg::RESP_SLVERR});
    chk(d, 32'h0);
    // a write without lane zero and a write to the flags change nothing
    wstrb <= 4'h0;
    wr(ca(0), 32'h31);
    chk({30'h0, r}, {30'h0, ewc_pkg::RESP_OKAY});
    wstrb <= 4'hF;
    wr(ad(ewc_pkg::IDX_FLAGS), 32'hF);
    chk({30'h0, r}, {30'h0, ewc_pkg::RESP_OKAY});
    rd(ca(0));
    chk(d, 32'h20);
    // disabled inputs never flag, whatever the pins do
    repeat (4) step(4'($urandom));
    rd(ad(ewc_pkg::IDX_FLAGS));
    chk(d, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // each round gives every input another condition code; the outside
    // interrupt level is taken as zero while conditions are changed
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) begin
        cd[i] = 2'(k + i);
        wr(ca(i), {26'h0, cd[i], 4'h0});
        chk({30'h0, r}, {30'h0, ewc_pkg::RESP_OKAY});
        rd(ca(i));
        chk(d, {26'h0, cd[i], 4'h0});
      end
      rd(ad(ewc_pkg::IDX_FLAGS));
      for (int i = 0; i < 4; i++)
        wr(ca(i), {26'h0, cd[i], 4'h1});
      en = 4'hF;
      mk = 4'($urandom);
      wr(ad(ewc_pkg::IDX_EVT_STATUS), 32'hF);
      wr(ad(ewc_pkg::IDX_EVT_MASK), {28'h0, mk});
      rd(ad(ewc_pkg::IDX_EVT_MASK));
      chk(d, {28'h0, mk});
      ef = lvl(mp);
      ev = ef;
      repeat (6) begin
        step(4'($urandom));
        chk({31'h0, wake}, {31'h0, |ef});
        chk({31'h0, irq}, {31'h0, |ef});
        chk({31'h0, evt_irq}, {31'h0, |(ev & mk)});
        rd(ad(ewc_pkg::IDX_EVT_STATUS));
        chk(d, {28'h0, ev});
        rd(ad(ewc_pkg::IDX_FLAGS));
        chk(d, {28'h0, ef});
        ef = lvl(mp);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, |ef});
        chk({31'h0, wake}, {31'h0, |ef});
        wr(ad(ewc_pkg::IDX_EVT_STATUS), 32'hF);
        ev = ef;
      end
    end
    // reset in mid-run: every register returns to its reset value
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    {en, ef, ev} = 12'h0;
    @(negedge clk);
    chk({29'h0, wake, irq, evt_irq}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(ca(i));
      chk(d, 32'h20);
    end
    rd(ad(ewc_pkg::IDX_FLAGS));
    chk(d, 32'h0);
    rd(ad(ewc_pkg::IDX_EVT_MASK));
    chk(d, 32'h0);
    conclude();
  end
endmodule
